// ---- pkg/bcsr_pkg.sv ----
// shared constants and types for the burst chip-select read controller
package bcsr_pkg;

  // operand size codes driven on xfer_size
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LINE = 2'h3;

  // port width codes on the port_size input
  localparam logic [1:0] PORT_32 = 2'h0;
  localparam logic [1:0] PORT_8 = 2'h1;
  localparam logic [1:0] PORT_16 = 2'h2;

  // byte lane positions on the data pins
  localparam int LANE_HI16_LSB = 16;
  localparam int LANE_HI8_LSB = 24;

  // low address bits that advance inside a line
  localparam int WRAP_BITS = 4;

  // idle levels of the bus pins
  localparam logic [3:0] WE_IDLE_N = 4'hf;
  localparam logic [27:0] ADDR_RST = 28'h0000000;

  // acknowledge arrives through a two-stage synchroniser
  localparam logic [1:0] ACK_PIPE = 2'h2;

  // bus monitor tick period
  localparam int CLK_PERIOD_NS = 50;
  localparam int BM_TICK_NS = 800;
  localparam int BM_TICK_CYC = (BM_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BM_LIMIT_W = 8;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_DATA = 5'h04,
    ST_HOLD = 5'h08,
    ST_SETUP = 5'h10
  } bcsr_state_e;

endpackage : bcsr_pkg

// ---- rtl/bcsr_bus_mon.sv ----
// bus monitor: counts prescaled ticks while waiting for an acknowledge
module bcsr_bus_mon #(
  parameter int LIMIT_W = bcsr_pkg::BM_LIMIT_W,
  parameter int TICK_CYC = bcsr_pkg::BM_TICK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  input wire logic enable,
  input wire logic clear,
  input wire logic [LIMIT_W-1:0] limit,
  // result
  output logic timeout
);

  typedef struct packed {
    logic [15:0] pre;
    logic [LIMIT_W-1:0] cnt;
    logic timeout;
  } bcsr_mon_s;

  bcsr_mon_s s_r;
  bcsr_mon_s s_nxt;
  logic tick;

  // divider free-runs into a one-cycle tick; a clear does not reset it, so the first tick after a clear can be partial
  assign tick = (s_r.pre == 16'(TICK_CYC - 1));

  // count while a beat waits; a clear restarts the measurement
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.timeout = 1'b0;
    s_nxt.pre = tick ? 16'h0000 : s_r.pre + 16'h0001;
    if (clear || !enable)
    begin
      s_nxt.cnt = '0;
    end
    else if (tick)
    begin
      if (s_r.cnt == limit)
        s_nxt.timeout = 1'b1;
      else
        s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign timeout = s_r.timeout;

endmodule : bcsr_bus_mon

// ---- rtl/bcsr_ctrl.sv ----
// burst read sequencer for chip-selected memory narrower than the operand
// Function
// - first clock drives valid address, transfer type and control outputs
// - begin strobe low in first clock, high from the second
// - access_kind high for code, low for data in first clock
// - access_kind shows supervisor high, user low from second clock
// - reads keep direction output and all byte write strobes high
// - xfer_size carries operand size: zero longword, two word
// - ack sampled each data clock; 16-bit port captures upper two lanes
// - 8-bit port captures only the top byte lane per acknowledge
// - negated acknowledge inserts wait states, sampled every clock
// - enabled bus monitor expiry ends the cycle with a bus error
// - longword on 16-bit port advances low two address bits per word
// - word on 8-bit port advances address bit zero per byte
// - without setup or read hold chip select stays low across beats, rises at end
// - with setup chip select high in address clock, low the next
// - with setup chip select rises after each non-final acknowledged beat
// - read hold keeps address and attributes one clock after each beat
// - write strobes never assert, so zero-wait setup writes show none
// - burst only when enabled and operand exceeds port, else single cycles
// - xfer_size shows three for line, zero for longword, any port
module bcsr_ctrl #(
  parameter int BM_TICK_CYC = bcsr_pkg::BM_TICK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // core request
  input wire logic req_valid,
  input wire logic [27:0] req_addr,
  input wire logic [1:0] req_type,
  input wire logic [1:0] req_size,
  input wire logic req_code,
  input wire logic req_super,
  output logic req_ready,
  // configuration
  input wire logic [1:0] port_size,
  input wire logic burst_en,
  input wire logic setup_delay_en,
  input wire logic read_hold_en,
  input wire logic bm_en,
  input wire logic [bcsr_pkg::BM_LIMIT_W-1:0] bm_limit,
  // core result
  output logic [31:0] rd_data,
  output logic rd_valid,
  output logic xfer_done,
  output logic bus_error,
  // memory bus pins
  output logic [27:0] addr_o,
  output logic [1:0] xfer_type,
  output logic [1:0] xfer_size,
  output logic access_kind,
  output logic rd_wr_n,
  output logic [3:0] write_en_n,
  output logic xfer_begin_n,
  output logic cs_n,
  input wire logic [31:0] data_i,
  input wire logic xfer_ack_n
);

  typedef struct packed {
    bcsr_pkg::bcsr_state_e st;
    logic [27:0] addr;
    logic [1:0] ttype;
    logic [1:0] size;
    logic code;
    logic priv;
    logic burst;
    logic [4:0] beats;
    logic [1:0] skip;
    logic [31:0] acc;
    logic [2:0] nbytes;
    logic ack_s1;
    logic ack_s2;
    logic [31:0] dat_s1;
    logic [31:0] dat_s2;
    logic start_n;
    logic cs_n;
    logic ak;
    logic [3:0] we_n;
    logic busy;
    logic bm_clr;
    logic [31:0] rd_data;
    logic rd_valid;
    logic done;
    logic err;
  } bcsr_ctrl_s;

  bcsr_ctrl_s s_r;
  bcsr_ctrl_s s_nxt;
  logic timeout;
  logic [2:0] port_bytes;
  logic [2:0] op_lg;
  logic [2:0] port_lg;
  logic [27:0] addr_inc;
  logic ack_seen;
  logic last;
  logic [31:0] acc_new;
  logic [2:0] nbytes_new;

  // log2 of operand bytes for a size code
  function automatic logic [2:0] op_log2(input logic [1:0] sz);
    case (sz)
      bcsr_pkg::SZ_BYTE: op_log2 = 3'h0;
      bcsr_pkg::SZ_WORD: op_log2 = 3'h1;
      bcsr_pkg::SZ_LINE: op_log2 = 3'h4;
      default: op_log2 = 3'h2;
    endcase
  endfunction : op_log2

  // port width decode
  always_comb
  begin
    case (port_size)
      bcsr_pkg::PORT_8:
      begin
        port_bytes = 3'h1;
        port_lg = 3'h0;
      end
      bcsr_pkg::PORT_16:
      begin
        port_bytes = 3'h2;
        port_lg = 3'h1;
      end
      default:
      begin
        port_bytes = 3'h4;
        port_lg = 3'h2;
      end
    endcase
  end

  // low bits wrap inside a line so a line burst stays in its 16 bytes
  assign addr_inc = {s_r.addr[27:bcsr_pkg::WRAP_BITS],
                     s_r.addr[bcsr_pkg::WRAP_BITS-1:0] + {1'b0, port_bytes}};

  // stale acks of the previous beat are still in the synchroniser
  assign ack_seen = !s_r.ack_s2 && (s_r.skip == 2'h0);
  assign last = (s_r.beats == 5'h01);

  // shift the new lanes in below the earlier beats
  always_comb
  begin
    case (port_size)
      bcsr_pkg::PORT_8:
        acc_new = {s_r.acc[23:0], s_r.dat_s2[bcsr_pkg::LANE_HI8_LSB +: 8]};
      bcsr_pkg::PORT_16:
        acc_new = {s_r.acc[15:0], s_r.dat_s2[bcsr_pkg::LANE_HI16_LSB +: 16]};
      default:
        acc_new = s_r.dat_s2;
    endcase
    nbytes_new = s_r.nbytes + port_bytes;
  end

  // sequencer
  always_comb
  begin
    op_lg = op_log2(req_size);
    s_nxt = s_r;
    s_nxt.ack_s1 = xfer_ack_n;
    s_nxt.ack_s2 = s_r.ack_s1;
    s_nxt.dat_s1 = data_i;
    s_nxt.dat_s2 = s_r.dat_s1;
    s_nxt.skip = (s_r.skip == 2'h0) ? 2'h0 : s_r.skip - 2'h1;
    s_nxt.rd_valid = 1'b0;
    s_nxt.done = 1'b0;
    s_nxt.err = 1'b0;
    s_nxt.bm_clr = 1'b0;
    s_nxt.we_n = bcsr_pkg::WE_IDLE_N;
    case (s_r.st)
      bcsr_pkg::ST_IDLE:
      begin
        if (req_valid)
        begin
          s_nxt.st = bcsr_pkg::ST_ADDR;
          s_nxt.addr = req_addr;
          s_nxt.ttype = req_type;
          s_nxt.size = req_size;
          s_nxt.code = req_code;
          s_nxt.priv = req_super;
          s_nxt.burst = burst_en && (op_lg > port_lg);
          s_nxt.beats = (op_lg > port_lg) ? 5'(5'h01 << (op_lg - port_lg)) : 5'h01;
          s_nxt.acc = 32'h00000000;
          s_nxt.nbytes = 3'h0;
          s_nxt.start_n = 1'b0;
          s_nxt.ak = req_code;
          s_nxt.cs_n = setup_delay_en;
          s_nxt.busy = 1'b1;
        end
      end
      bcsr_pkg::ST_ADDR:
      begin
        s_nxt.st = bcsr_pkg::ST_DATA;
        s_nxt.start_n = 1'b1;
        s_nxt.ak = s_r.priv;
        s_nxt.cs_n = 1'b0;
      end
      bcsr_pkg::ST_SETUP:
      begin
        s_nxt.st = bcsr_pkg::ST_DATA;
        s_nxt.cs_n = 1'b0;
      end
      bcsr_pkg::ST_DATA:
      begin
        if (timeout)
        begin
          // no acknowledge in time: drop the cycle
          s_nxt.st = bcsr_pkg::ST_IDLE;
          s_nxt.cs_n = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.err = 1'b1;
        end
        else if (ack_seen)
        begin
          s_nxt.acc = acc_new;
          s_nxt.beats = s_r.beats - 5'h01;
          s_nxt.skip = bcsr_pkg::ACK_PIPE;
          s_nxt.bm_clr = 1'b1;
          s_nxt.cs_n = 1'b1;
          if (nbytes_new[2] || last)
          begin
            s_nxt.rd_data = acc_new;
            s_nxt.rd_valid = 1'b1;
            s_nxt.nbytes = 3'h0;
          end
          else
          begin
            s_nxt.nbytes = nbytes_new;
          end
          if (read_hold_en)
          begin
            s_nxt.st = bcsr_pkg::ST_HOLD;
          end
          else if (last)
          begin
            s_nxt.st = bcsr_pkg::ST_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
          end
          else if (!s_r.burst)
          begin
            // separate cycle per beat when burst is not allowed
            s_nxt.st = bcsr_pkg::ST_ADDR;
            s_nxt.addr = addr_inc;
            s_nxt.start_n = 1'b0;
            s_nxt.ak = s_r.code;
            s_nxt.cs_n = setup_delay_en;
          end
          else if (setup_delay_en)
          begin
            s_nxt.st = bcsr_pkg::ST_SETUP;
            s_nxt.addr = addr_inc;
          end
          else
          begin
            s_nxt.addr = addr_inc;
            s_nxt.cs_n = 1'b0;
          end
        end
      end
      bcsr_pkg::ST_HOLD:
      begin
        // address and attributes were held one clock; now move on
        if (s_r.beats == 5'h00)
        begin
          s_nxt.st = bcsr_pkg::ST_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
        end
        else
        begin
          s_nxt.addr = addr_inc;
          if (!s_r.burst)
          begin
            s_nxt.st = bcsr_pkg::ST_ADDR;
            s_nxt.start_n = 1'b0;
            s_nxt.ak = s_r.code;
            s_nxt.cs_n = setup_delay_en;
          end
          else if (setup_delay_en)
          begin
            s_nxt.st = bcsr_pkg::ST_SETUP;
          end
          else
          begin
            s_nxt.st = bcsr_pkg::ST_DATA;
            s_nxt.cs_n = 1'b0;
          end
        end
      end
      default:
      begin
        s_nxt.st = bcsr_pkg::ST_IDLE;
        s_nxt.cs_n = 1'b1;
        s_nxt.start_n = 1'b1;
        s_nxt.busy = 1'b0;
      end
    endcase
  end

  // state register; pins park inactive after reset
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      s_r <= '0;
      s_r.st <= bcsr_pkg::ST_IDLE;
      s_r.addr <= bcsr_pkg::ADDR_RST;
      s_r.ack_s1 <= 1'b1;
      s_r.ack_s2 <= 1'b1;
      s_r.start_n <= 1'b1;
      s_r.cs_n <= 1'b1;
      s_r.we_n <= bcsr_pkg::WE_IDLE_N;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // timer restarts on each beat so it measures the wait for one ack
  bcsr_bus_mon #(
    .LIMIT_W(bcsr_pkg::BM_LIMIT_W),
    .TICK_CYC(BM_TICK_CYC)
  ) i_bcsr_bus_mon (
    .clk(clk),
    .resetn(resetn),
    .enable(bm_en),
    .clear((s_r.st != bcsr_pkg::ST_DATA) || s_r.bm_clr),
    .limit(bm_limit),
    .timeout(timeout)
  );

  // outputs straight from the state register, except rd_wr_n which is tied high
  assign req_ready = !s_r.busy;
  assign rd_data = s_r.rd_data;
  assign rd_valid = s_r.rd_valid;
  assign xfer_done = s_r.done;
  assign bus_error = s_r.err;
  assign addr_o = s_r.addr;
  assign xfer_type = s_r.ttype;
  assign xfer_size = s_r.size;
  assign access_kind = s_r.ak;
  assign rd_wr_n = 1'b1;
  assign write_en_n = s_r.we_n;
  assign xfer_begin_n = s_r.start_n;
  assign cs_n = s_r.cs_n;

endmodule : bcsr_ctrl

// ---- dv/bcsr_ctrl_properties.sv ----
// bus timing properties of the burst read controller, bound to its ports
module bcsr_ctrl_properties (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // core side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [27:0] req_addr,
  input wire logic [1:0] req_type,
  input wire logic [1:0] req_size,
  input wire logic req_code,
  input wire logic req_super,
  input wire logic burst_en,
  input wire logic setup_delay_en,
  input wire logic read_hold_en,
  input wire logic bm_en,
  input wire logic xfer_done,
  input wire logic bus_error,
  // memory pins
  input wire logic [27:0] addr_o,
  input wire logic [1:0] xfer_type,
  input wire logic [1:0] xfer_size,
  input wire logic access_kind,
  input wire logic rd_wr_n,
  input wire logic [3:0] write_en_n,
  input wire logic xfer_begin_n,
  input wire logic cs_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // first clock carries the request attributes
  property p_first;
    req_valid && req_ready |=> !xfer_begin_n && access_kind == $past(req_code)
      && addr_o == $past(req_addr) && xfer_type == $past(req_type);
  endproperty
  a_first: assert property (p_first) else $error("first clock attributes wrong");
  property p_super;
    req_valid && req_ready |=> ##1 access_kind == $past(req_super, 2);
  endproperty
  a_super: assert property (p_super) else $error("privilege not shown");
  property p_begin;
    !xfer_begin_n |=> xfer_begin_n;
  endproperty
  a_begin: assert property (p_begin) else $error("begin strobe too long");
  property p_read;
    rd_wr_n && write_en_n == bcsr_pkg::WE_IDLE_N;
  endproperty
  a_read: assert property (p_read) else $error("write strobe active");
  property p_size;
    req_valid && req_ready |=> xfer_size == $past(req_size);
  endproperty
  a_size: assert property (p_size) else $error("size code wrong");
  // setup: select held off in the address clock only
  property p_setup;
    setup_delay_en && !xfer_begin_n |-> cs_n ##1 !cs_n;
  endproperty
  a_setup: assert property (p_setup) else $error("select timing with setup");
  property p_nosetup;
    !setup_delay_en && !read_hold_en && burst_en && !cs_n |=> !cs_n || xfer_done || bus_error;
  endproperty
  a_nosetup: assert property (p_nosetup) else $error("select dropped mid burst");
  property p_end;
    xfer_done || bus_error |-> cs_n;
  endproperty
  a_end: assert property (p_end) else $error("select left active");
  property p_err;
    bus_error |-> bm_en;
  endproperty
  a_err: assert property (p_err) else $error("error without monitor");
  // only the low four bits move inside a cycle
  property p_frame;
    !req_ready && $past(!req_ready) |-> addr_o[27:4] == $past(addr_o[27:4]);
  endproperty
  a_frame: assert property (p_frame) else $error("upper address moved");
  property p_adv;
    setup_delay_en && !read_hold_en && $rose(cs_n) && !req_ready |=> !cs_n;
  endproperty
  a_adv: assert property (p_adv) else $error("select gap not one clock");
  property p_hold;
    read_hold_en && $rose(cs_n) && !req_ready |-> addr_o == $past(addr_o);
  endproperty
  a_hold: assert property (p_hold) else $error("address not held");
  c_err: cover property (bus_error);
  c_setup: cover property (setup_delay_en && !xfer_begin_n);
  c_line: cover property (xfer_done && xfer_size == bcsr_pkg::SZ_LINE);
endmodule : bcsr_ctrl_properties

// ---- dv/bcsr_mem_model.sv ----
// chip-selected memory: addressed bytes on the upper lanes, ack after a wait
module bcsr_mem_model (
  // clock
  input wire logic clk,
  // pins from the controller; port width and wait count from the test
  input wire logic cs_n,
  input wire logic [27:0] addr_o,
  input wire logic [1:0] port_size,
  input wire logic [7:0] wt,
  // pins to the controller
  output logic [31:0] data_i,
  output logic xfer_ack_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r;
  logic [27:0] adr_r;
  logic [31:0] d;
  function automatic logic [7:0] b(input logic [27:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction : b
  // wait counter restarts per address; wt of ff never acks
  always_ff @(posedge clk)
  begin
    adr_r <= addr_o;
    cnt_r <= (cs_n || addr_o != adr_r) ? 8'h00 : cnt_r + 8'((cnt_r < 8'hfe) ? 1 : 0);
  end
  assign d = {b(addr_o), b(addr_o + 28'h1), b(addr_o + 28'h2), b(addr_o + 28'h3)};
  // unused lanes and deselected bus carry junk, never a stale match
  always_comb
  begin
    // no ack while the address is still new: the wait count belongs to the old one
    xfer_ack_n = !(!cs_n && addr_o == adr_r && cnt_r >= wt);
    if (cs_n)
      data_i = ~d;
    else if (port_size == bcsr_pkg::PORT_16)
      data_i = {d[31:16], ~d[15:0]};
    else if (port_size == bcsr_pkg::PORT_8)
      data_i = {d[31:24], ~d[23:0]};
    else
      data_i = d;
  end
endmodule : bcsr_mem_model

// ---- dv/bcsr_ctrl_tb_top.sv ----
// top testbench: read requests against the memory model
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); \
    end \
  end
module bcsr_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, req_valid, req_code, req_super, req_ready, burst_en, setup_delay_en;
  logic read_hold_en, bm_en, rd_valid, xfer_done, bus_error, access_kind, rd_wr_n;
  logic xfer_begin_n, cs_n, xfer_ack_n;
  logic [27:0] req_addr, addr_o;
  logic [1:0] req_type, req_size, port_size, xfer_type, xfer_size;
  logic [7:0] bm_limit, wt;
  logic [31:0] rd_data, data_i;
  logic [3:0] write_en_n;
  int n_fail = 0;
  int checks_done = 0;
  int tn = 0;
  bcsr_ctrl #(.BM_TICK_CYC(2)) i_bcsr_ctrl (.clk(clk), .resetn(resetn),
    .req_valid(req_valid), .req_addr(req_addr), .req_type(req_type), .req_size(req_size),
    .req_code(req_code), .req_super(req_super), .req_ready(req_ready),
    .port_size(port_size), .burst_en(burst_en), .setup_delay_en(setup_delay_en),
    .read_hold_en(read_hold_en), .bm_en(bm_en), .bm_limit(bm_limit), .rd_data(rd_data),
    .rd_valid(rd_valid), .xfer_done(xfer_done), .bus_error(bus_error), .addr_o(addr_o),
    .xfer_type(xfer_type), .xfer_size(xfer_size), .access_kind(access_kind),
    .rd_wr_n(rd_wr_n), .write_en_n(write_en_n), .xfer_begin_n(xfer_begin_n),
    .cs_n(cs_n), .data_i(data_i), .xfer_ack_n(xfer_ack_n));
  bcsr_mem_model i_bcsr_mem_model (.clk(clk), .cs_n(cs_n), .addr_o(addr_o),
    .port_size(port_size), .wt(wt), .data_i(data_i), .xfer_ack_n(xfer_ack_n));
  function automatic logic [7:0] b(input logic [27:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction : b
  task automatic results;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  // one read request, data checked on every rd_valid, begins counted
  task automatic rd(input logic [27:0] a, input logic [1:0] sz, input logic [1:0] ps,
    input logic [3:0] cfg, input logic [7:0] w, input int nb, input logic err);
    int k, nbeg, nrv;
    logic fin, seen_err;
    logic [27:0] x;
    logic [31:0] m;
    k = 0;
    nbeg = 0;
    nrv = 0;
    fin = 1'b0;
    seen_err = 1'b0;
    m = (sz == bcsr_pkg::SZ_WORD) ? 32'h0000ffff : (sz == bcsr_pkg::SZ_BYTE) ? 32'h000000ff : '1;
    @(posedge clk);
    {burst_en, setup_delay_en, read_hold_en, bm_en} <= cfg;
    port_size <= ps;
    wt <= w;
    req_addr <= a;
    req_size <= sz;
    req_code <= a[4];
    req_super <= a[5];
    req_type <= a[7:6];
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    while (!fin && k < 2000)
    begin
      #1;
      if (xfer_begin_n === 1'b0)
        nbeg++;
      if (rd_valid === 1'b1)
      begin
        x = a + 28'(4 * nrv);
        `CHK(rd_data & m, {b(x), b(x + 28'h1), b(x + 28'h2), b(x + 28'h3)} >> (32 - $countones(m)))
        nrv++;
      end
      // the error pulse is gone by the loop's exit edge, so latch it here
      if (bus_error === 1'b1)
        seen_err = 1'b1;
      fin = (xfer_done === 1'b1) || (bus_error === 1'b1);
      @(posedge clk);
      k++;
    end
    if (!fin)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t no completion", $time);
      results();
    end
    `CHK(seen_err, err)
    `CHK(nbeg, nb)
    `CHK(nrv, err ? 0 : (sz == bcsr_pkg::SZ_LINE ? 4 : 1))
    tn++;
    $display("test %0d done", tn);
  endtask : rd
  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    {resetn, req_valid, req_code, req_super, burst_en, setup_delay_en} = '0;
    {read_hold_en, bm_en, req_addr, req_type, req_size, port_size, wt} = '0;
    bm_limit = 8'h03;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd(28'h0001230, bcsr_pkg::SZ_LONG, bcsr_pkg::PORT_16, 4'b1000, 8'h00, 1, 1'b0);
    rd(28'h00012f0, bcsr_pkg::SZ_LONG, bcsr_pkg::PORT_16, 4'b1100, 8'h02, 1, 1'b0);
    rd(28'h0004562, bcsr_pkg::SZ_WORD, bcsr_pkg::PORT_8, 4'b1110, 8'h00, 1, 1'b0);
    rd(28'h0007890, bcsr_pkg::SZ_LINE, bcsr_pkg::PORT_16, 4'b1000, 8'h01, 1, 1'b0);
    rd(28'h0001238, bcsr_pkg::SZ_LONG, bcsr_pkg::PORT_16, 4'b0000, 8'h00, 2, 1'b0);
    rd(28'h000abc4, bcsr_pkg::SZ_LONG, bcsr_pkg::PORT_32, 4'b1000, 8'h00, 1, 1'b0);
    rd(28'h0003330, bcsr_pkg::SZ_LONG, bcsr_pkg::PORT_8, 4'b1001, 8'hff, 1, 1'b1);
    rd(28'h00033e1, bcsr_pkg::SZ_BYTE, bcsr_pkg::PORT_8, 4'b1000, 8'h04, 1, 1'b0);
    rd(28'h0005674, bcsr_pkg::SZ_LONG, bcsr_pkg::PORT_8, 4'b1010, 8'h01, 1, 1'b0);
    rd(28'h0004568, bcsr_pkg::SZ_WORD, bcsr_pkg::PORT_8, 4'b0100, 8'h00, 2, 1'b0);
    results();
  end
endmodule : bcsr_ctrl_tb_top
bind bcsr_ctrl bcsr_ctrl_properties i_bcsr_ctrl_properties (.clk(clk), .resetn(resetn),
  .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr), .req_type(req_type),
  .req_size(req_size), .req_code(req_code), .req_super(req_super), .burst_en(burst_en),
  .setup_delay_en(setup_delay_en), .read_hold_en(read_hold_en), .bm_en(bm_en),
  .xfer_done(xfer_done), .bus_error(bus_error), .addr_o(addr_o), .xfer_type(xfer_type),
  .xfer_size(xfer_size), .access_kind(access_kind), .rd_wr_n(rd_wr_n),
  .write_en_n(write_en_n), .xfer_begin_n(xfer_begin_n), .cs_n(cs_n));
